// ### src/cap_defs.vh
// Summary of operation
// RL1 - Set busy holds until a terminating code
// RL2 - Adapter clear restores normal half-duplex operation
// RL3 - Adapter clear wipes port status and sense
// RL4 - Monitor enable re-arms data-set-ready monitor
// RL5 - Full-duplex command; master clear forces half-duplex
// RL6 - Control byte load starts at coded byte
// RL7 - Byte 1 low nibble zero clears adapter
// RL8 - Overflow bytes act as sense; last byte ends
// RL9 - Control byte 2 picks detect table
// RL10 - Detect tables 256 five-bit entries, cleared
// RL11 - Table commands pre-clear the addressed port
// RL12 - Control byte 3 picks interpretation word set
// RL13 - Interpretation tables never reset
// RL14 - Line test loops output, sets full-duplex
// RL15 - Modem test loops modem, sets full-duplex
// RL16 - Port control word order, zero padding, wrap
// RL17 - Control word readout ends on last byte
// RL18 - Check-character byte reads zero without error
// RL19 - Detect table read 00 to FF, ends last
// RL20 - Interpretation read follows detect read handling
// RL21 - Two-bit condition code after each start
// RL22 - Reject parity, invalid code, missing adapter
// RL23 - Reject sets unit check with sense bits
// RL24 - Master clear zeroes all control bytes
// RL25 - Each table command restarts pointer at 00
// RL26 - Per-port state changes only addressed port
`ifndef CAP_DEFS_VH
`define CAP_DEFS_VH

// ------------
// Command codes and masks
// ------------
`define CAP_CMD_SET_BUSY 8'h1F
`define CAP_CMD_DSR_MON 8'h17
`define CAP_CMD_FULL_DUP 8'h1B
`define CAP_CMD_LINE_TEST 8'h0B
`define CAP_CMD_MODEM_TEST 8'h07
`define CAP_CMD_READ_PCW 8'h16
`define CAP_LOW_CLEAR 6'h0F
`define CAP_LOW_LOAD_CB 6'h15
`define CAP_LOW_LOAD_CD 6'h19
`define CAP_LOW_READ_CD 6'h1A
`define CAP_LOW_LOAD_CI 6'h1D
`define CAP_LOW_READ_CI 6'h1E

// ------------
// Condition codes and sense bits
// ------------
`define CAP_CC_ACCEPT 2'h0
`define CAP_CC_REJECT 2'h1
`define CAP_CC_BUSY 2'h2
`define CAP_CC_OFFLINE 2'h3
`define CAP_SNS_CMD_REJ 0
`define CAP_SNS_BUS_OUT 2
`define CAP_SNS_DSR 6
`define CAP_CB4_DIAL 6

// ------------
// Register offsets and reset values
// ------------
`define CAP_REG_CONFIG 4'h0
`define CAP_REG_STATUS 4'h4
`define CAP_CFG_OFFLINE 0
`define CAP_CFG_ATTACH_LSB 8
`define CAP_RST_ATTACH 8'hFF
`define CAP_WIPE_LAST 10'h3FF

// ------------
// Control word layout (zero-based byte index)
// ------------
`define CAP_PCW_CRC 5'h09
`define CAP_PCW_CB2_A 5'h0A
`define CAP_PCW_SNS0 5'h0B
`define CAP_PCW_CB2_B 5'h0C
`define CAP_PCW_CB1_A 5'h0D
`define CAP_PCW_CB1_B 5'h0E
`define CAP_PCW_CB3_A 5'h12
`define CAP_PCW_SNS1 5'h13
`define CAP_PCW_CB3_B 5'h14
`define CAP_PCW_CB4_A 5'h15
`define CAP_PCW_CB4_B 5'h16

`endif

// ### src/cap_port_flags.v
`timescale 1ns/10ps
// Mode flags of one multiplexer port.
module cap_port_flags (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_clear,
  input wire i_set_fd,
  input wire i_set_busy,
  input wire i_end_busy,
  input wire i_mon_en,
  input wire i_dsr_event,
  input wire i_line_test,
  input wire i_modem_test,
  output reg o_full_duplex,
  output reg o_busy_out,
  output reg o_dsr_mon,
  output reg o_dsr_seen,
  output reg o_line_loop,
  output reg o_modem_loop
);

  // ------------
  // Flag update
  // ------------
  // Clear has priority over the test and full-duplex commands when both
  // arrive together for one port.
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_full_duplex <= 1'b0; // RL5
      o_busy_out <= 1'b0;
      o_dsr_mon <= 1'b1;
      o_dsr_seen <= 1'b0;
      o_line_loop <= 1'b0;
      o_modem_loop <= 1'b0;
    end else begin
      if (i_clear) begin
        // Back to normal half-duplex operation, loops dropped.
        o_full_duplex <= 1'b0; // RL2
        o_line_loop <= 1'b0; // RL2
        o_modem_loop <= 1'b0; // RL2
        o_dsr_seen <= i_dsr_event & o_dsr_mon; // RL3
      end else begin
        if (i_set_fd) begin
          o_full_duplex <= 1'b1; // RL5
        end
        if (i_line_test) begin
          o_line_loop <= 1'b1; // RL14
        end
        if (i_modem_test) begin
          o_modem_loop <= 1'b1; // RL15
        end
        if (i_dsr_event & o_dsr_mon) begin
          o_dsr_seen <= 1'b1;
        end
      end
      // The monitor disarms after it reports and rearms on command.
      if (i_mon_en) begin
        o_dsr_mon <= 1'b1; // RL4
      end else if (i_dsr_event & o_dsr_mon) begin
        o_dsr_mon <= 1'b0; // RL4
      end
      // Busy appearance does not touch the active state.
      if (i_set_busy) begin
        o_busy_out <= 1'b1; // RL1
      end else if (i_end_busy) begin
        o_busy_out <= 1'b0; // RL1
      end
    end
  end

endmodule

// ### src/cap_port_cmd.v
`timescale 1ns/10ps
`include "cap_defs.vh"
// Command interpreter of the multi-port communications adapter.
module cap_port_cmd (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [3:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire i_sio_valid,
  input wire [7:0] i_sio_code,
  input wire i_sio_parity_ok,
  input wire [2:0] i_sio_port,
  output reg o_sio_done,
  output reg [1:0] o_cond_code,
  output reg o_status_valid,
  output reg o_unit_check,
  output reg o_device_end,
  output reg o_data_req,
  output reg o_data_dir,
  input wire i_byte_strobe,
  input wire [7:0] i_byte_data,
  input wire i_last_byte,
  output reg [7:0] o_byte_data,
  input wire [7:0] i_dsr_event,
  input wire i_rx_valid,
  input wire [2:0] i_rx_port,
  input wire [7:0] i_rx_char,
  output reg o_cd_valid,
  output reg [4:0] o_cd_code,
  output reg o_ci_valid,
  output reg [11:0] o_ci_func,
  output wire [7:0] o_full_duplex,
  output wire [7:0] o_busy_out,
  output wire [7:0] o_dsr_mon,
  output wire [7:0] o_line_loop,
  output wire [7:0] o_modem_loop
);

  // ------------
  // Transfer operations
  // ------------
  localparam OP_NONE = 3'h0;
  localparam OP_LDCB = 3'h1;
  localparam OP_LDCD = 3'h2;
  localparam OP_LDCI = 3'h3;
  localparam OP_RDPCW = 3'h4;
  localparam OP_RDCD = 3'h5;
  localparam OP_RDCI = 3'h6;

  // ------------
  // Storage
  // ------------
  reg [7:0] cb [0:31]; // Four control bytes per port.
  reg [7:0] sns0 [0:7]; // Sense byte 0 per port.
  reg [4:0] cd_mem [0:1023]; // Four detect tables of 256 codes.
  reg [11:0] ci_mem [0:63]; // Four interpretation tables of 16 words.
  reg clearing; // Detect-table wipe after master clear.
  reg [9:0] clr_cnt; // Wipe address.
  reg cfg_offline; // Software takes the adapter offline.
  reg [7:0] cfg_attach; // Ports with an adapter fitted.
  reg [1:0] last_cc; // Last condition code given.
  reg [2:0] op; // Running data transfer.
  reg [2:0] xport; // Port of the running transfer.
  reg [1:0] xtbl; // Table chosen by the command.
  reg [7:0] ptr; // Table or word byte pointer.
  reg [2:0] cb_idx; // Next control byte to load.
  reg [3:0] ci_hi; // Upper nibble of an interpretation word.
  reg [2:0] rx_port_q; // Port of the char being looked up.
  reg [7:0] rd_byte; // Byte offered to the channel.
  reg [1:0] next_cc; // Condition code for this start.
  wire [7:0] sns1 [0:7]; // Sense byte 1 per port.
  wire [7:0] dsr_seen;
  integer i;

  // ------------
  // Command decode
  // ------------
  wire [5:0] low6 = i_sio_code[5:0];
  wire [1:0] csel = i_sio_code[7:6];
  wire is_invalid = (i_sio_code[3:0] == 4'h8) | (i_sio_code[3:0] == 4'hC) |
    (i_sio_code[4:0] == 5'h10) | (i_sio_code[4:0] == 5'h14); // RL22
  wire is_ldcb = (low6 == `CAP_LOW_LOAD_CB);
  wire is_table = (low6 == `CAP_LOW_LOAD_CD) | (low6 == `CAP_LOW_READ_CD) |
    (low6 == `CAP_LOW_LOAD_CI) | (low6 == `CAP_LOW_READ_CI);
  wire is_pcw = (i_sio_code == `CAP_CMD_READ_PCW);
  wire is_data = is_ldcb | is_table | is_pcw;
  wire is_clear = (low6 == `CAP_LOW_CLEAR);
  wire accept = i_sio_valid & (next_cc == `CAP_CC_ACCEPT);
  wire [7:0] dec = 8'h01 << i_sio_port;
  wire xfer_on = (op != OP_NONE);
  wire take = i_byte_strobe & xfer_on;
  wire [7:0] xdec = 8'h01 << xport;

  // Codes that end the busy appearance of a port.
  wire ends_busy = (i_sio_code == 8'h01) | (i_sio_code == 8'h11) |
    (i_sio_code == 8'h0D) | (i_sio_code == 8'h09) | (i_sio_code == 8'h02) |
    (i_sio_code == 8'h03) | (i_sio_code == 8'h0B) | (i_sio_code == 8'h0F) |
    (i_sio_code == 8'h17) | (i_sio_code == 8'h1B);

  // Control byte 1 loaded with a zero low nibble acts as a clear.
  wire cb1_clear = take & (op == OP_LDCB) & (cb_idx == 3'h0) &
    (i_byte_data[3:0] == 4'h0); // RL7

  // Per-port clear: explicit clear, table pre-clear or byte 1 zero.
  wire [7:0] clr_vec = ((accept & (is_clear | is_table)) ? dec : 8'h00) |
    (cb1_clear ? xdec : 8'h00); // RL3 RL11 RL19 RL20

  // ------------
  // Condition code selection
  // ------------
  // Offline wins, then reject causes, then busy for a second data
  // command or while the tables are still being wiped.
  always @* begin
    if (cfg_offline) begin
      next_cc = `CAP_CC_OFFLINE; // RL21
    end else if (!i_sio_parity_ok || is_invalid || !cfg_attach[i_sio_port]) begin
      next_cc = `CAP_CC_REJECT; // RL22
    end else if (clearing || (is_data && xfer_on)) begin
      next_cc = `CAP_CC_BUSY; // RL21
    end else begin
      next_cc = `CAP_CC_ACCEPT; // RL21
    end
  end

  // ------------
  // Per-port mode flags
  // ------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : port
      cap_port_flags u_flags (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_clear(clr_vec[g]),
        .i_set_fd(accept & dec[g] & ((i_sio_code == `CAP_CMD_FULL_DUP) |
          (i_sio_code == `CAP_CMD_LINE_TEST) | (i_sio_code == `CAP_CMD_MODEM_TEST))),
        .i_set_busy(accept & dec[g] & (i_sio_code == `CAP_CMD_SET_BUSY)),
        .i_end_busy(accept & dec[g] & ends_busy),
        .i_mon_en(accept & dec[g] & (i_sio_code == `CAP_CMD_DSR_MON)),
        .i_dsr_event(i_dsr_event[g]),
        .i_line_test(accept & dec[g] & (i_sio_code == `CAP_CMD_LINE_TEST)),
        .i_modem_test(accept & dec[g] & (i_sio_code == `CAP_CMD_MODEM_TEST)),
        .o_full_duplex(o_full_duplex[g]),
        .o_busy_out(o_busy_out[g]),
        .o_dsr_mon(o_dsr_mon[g]),
        .o_dsr_seen(dsr_seen[g]),
        .o_line_loop(o_line_loop[g]),
        .o_modem_loop(o_modem_loop[g])
      ); // RL26
      assign sns1[g] = {1'b0, dsr_seen[g], 6'h00}; // RL4
    end
  endgenerate

  // ------------
  // Byte offered for read transfers
  // ------------
  // The check-character byte always reads zero: no error is kept.
  always @* begin
    rd_byte = 8'h00;
    case (op)
      OP_RDPCW: begin
        case (ptr[4:0])
          `CAP_PCW_CB2_A, `CAP_PCW_CB2_B: rd_byte = cb[{xport, 2'h1}]; // RL16
          `CAP_PCW_SNS0: rd_byte = sns0[xport]; // RL16
          `CAP_PCW_CB1_A, `CAP_PCW_CB1_B: rd_byte = cb[{xport, 2'h0}]; // RL16
          `CAP_PCW_CB3_A, `CAP_PCW_CB3_B: rd_byte = cb[{xport, 2'h2}]; // RL16
          `CAP_PCW_SNS1: rd_byte = sns1[xport]; // RL16
          `CAP_PCW_CB4_A, `CAP_PCW_CB4_B: rd_byte = cb[{xport, 2'h3}]; // RL16
          `CAP_PCW_CRC: rd_byte = 8'h00; // RL18
          default: rd_byte = 8'h00; // RL16
        endcase
      end
      OP_RDCD: begin
        rd_byte = {3'h0, cd_mem[{xtbl, ptr}]}; // RL19
      end
      OP_RDCI: begin
        // High nibble first, then the low eight bits.
        if (ptr[0]) begin
          rd_byte = ci_mem[{xtbl, ptr[4:1]}][7:0]; // RL20
        end else begin
          rd_byte = {4'h0, ci_mem[{xtbl, ptr[4:1]}][11:8]}; // RL20
        end
      end
      OP_LDCB: begin
        // The first two bytes past control byte 4 return sense bytes 0 and 1.
        if (cb_idx[2]) begin
          if (ptr == 8'h00) begin
            rd_byte = sns0[xport]; // RL8
          end else if (ptr == 8'h01) begin
            rd_byte = sns1[xport]; // RL8
          end
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // ------------
  // Table memories, written without reset
  // ------------
  // The detect tables are wiped by a sweep after master clear; the
  // interpretation tables keep their contents.
  always @(posedge i_clock) begin
    if (clearing) begin
      cd_mem[clr_cnt] <= 5'h00; // RL10
    end else if (take && op == OP_LDCD) begin
      cd_mem[{xtbl, ptr}] <= i_byte_data[4:0]; // RL10
    end
    if (take && op == OP_LDCI && ptr[0]) begin
      ci_mem[{xtbl, ptr[4:1]}] <= {ci_hi, i_byte_data}; // RL12 RL13
    end
  end

  // ------------
  // Character detect and interpretation lookup
  // ------------
  // Dial ports skip detection; the detect code picks an interpretation
  // word whose set bits each start a function.
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cd_valid <= 1'b0;
      o_cd_code <= 5'h00;
      o_ci_valid <= 1'b0;
      o_ci_func <= 12'h000;
      rx_port_q <= 3'h0;
    end else begin
      o_cd_valid <= i_rx_valid & ~cb[{i_rx_port, 2'h3}][`CAP_CB4_DIAL]; // RL9
      o_cd_code <= cd_mem[{cb[{i_rx_port, 2'h1}][1:0], i_rx_char}]; // RL9
      rx_port_q <= i_rx_port;
      o_ci_valid <= o_cd_valid;
      o_ci_func <= ci_mem[{cb[{rx_port_q, 2'h2}][1:0], o_cd_code[3:0]}]; // RL12
    end
  end

  // ------------
  // Start handling, transfers and status
  // ------------
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (i = 0; i < 32; i = i + 1) begin
        cb[i] <= 8'h00; // RL24
      end
      for (i = 0; i < 8; i = i + 1) begin
        sns0[i] <= 8'h00;
      end
      clearing <= 1'b1; // RL10
      clr_cnt <= 10'h000;
      op <= OP_NONE;
      xport <= 3'h0;
      xtbl <= 2'h0;
      ptr <= 8'h00;
      cb_idx <= 3'h0;
      ci_hi <= 4'h0;
      last_cc <= `CAP_CC_ACCEPT;
      o_sio_done <= 1'b0;
      o_cond_code <= `CAP_CC_ACCEPT;
      o_status_valid <= 1'b0;
      o_unit_check <= 1'b0;
      o_device_end <= 1'b0;
      o_data_req <= 1'b0;
      o_data_dir <= 1'b0;
      o_byte_data <= 8'h00;
    end else begin
      o_sio_done <= i_sio_valid;
      o_status_valid <= 1'b0;
      o_unit_check <= 1'b0;
      o_device_end <= 1'b0;
      // Wipe sweep over all four detect tables.
      if (clearing) begin
        clr_cnt <= clr_cnt + 10'h001;
        if (clr_cnt == `CAP_WIPE_LAST) begin
          clearing <= 1'b0;
        end
      end
      // Sense byte 0 is wiped by a clear of its port.
      for (i = 0; i < 8; i = i + 1) begin
        if (clr_vec[i]) begin
          sns0[i] <= 8'h00; // RL3
        end
      end
      if (i_sio_valid) begin
        o_cond_code <= next_cc; // RL21
        last_cc <= next_cc;
        if (next_cc == `CAP_CC_REJECT) begin
          // Rejects report unit check with the cause in sense byte 0.
          o_status_valid <= 1'b1; // RL23
          o_unit_check <= 1'b1; // RL23
          if (!i_sio_parity_ok) begin
            sns0[i_sio_port][`CAP_SNS_BUS_OUT] <= 1'b1; // RL23
          end else begin
            sns0[i_sio_port][`CAP_SNS_CMD_REJ] <= 1'b1; // RL23
          end
        end
      end
      if (accept && is_data) begin
        xport <= i_sio_port;
        xtbl <= csel;
        ptr <= 8'h00; // RL25
        cb_idx <= {1'b0, csel}; // RL6
        if (is_ldcb) begin
          op <= OP_LDCB;
        end else if (is_pcw) begin
          op <= OP_RDPCW;
        end else begin
          case (low6)
            `CAP_LOW_LOAD_CD: op <= OP_LDCD; // RL11
            `CAP_LOW_READ_CD: op <= OP_RDCD; // RL19
            `CAP_LOW_LOAD_CI: op <= OP_LDCI; // RL12
            default: op <= OP_RDCI; // RL20
          endcase
        end
      end else if (take) begin
        if (op == OP_LDCB && !cb_idx[2]) begin
          cb[{xport, cb_idx[1:0]}] <= i_byte_data; // RL6
          cb_idx <= cb_idx + 3'h1; // RL6
        end else begin
          // The pointer wraps by itself.
          ptr <= ptr + 8'h01; // RL16 RL19
        end
        if (op == OP_LDCI && !ptr[0]) begin
          ci_hi <= i_byte_data[3:0];
        end
        // The channel's last byte ends every transfer.
        if (i_last_byte) begin
          op <= OP_NONE; // RL8 RL17 RL19
          o_status_valid <= 1'b1;
          o_device_end <= 1'b1;
        end
      end
      o_data_req <= xfer_on;
      o_data_dir <= (op == OP_RDPCW) | (op == OP_RDCD) | (op == OP_RDCI) |
        ((op == OP_LDCB) & cb_idx[2]);
      o_byte_data <= rd_byte;
    end
  end

  // ------------
  // Wishbone register slave
  // ------------
  // One wait state; unmapped reads return zero and writes are dropped.
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      cfg_offline <= 1'b0;
      cfg_attach <= `CAP_RST_ATTACH;
    end else begin
      o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
      if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
        o_wb_dat <= 32'h00000000;
        if (i_wb_adr == `CAP_REG_CONFIG) begin
          if (i_wb_we) begin
            if (i_wb_sel[0]) begin
              cfg_offline <= i_wb_dat[`CAP_CFG_OFFLINE];
            end
            if (i_wb_sel[1]) begin
              cfg_attach <= i_wb_dat[15:8];
            end
          end else begin
            o_wb_dat <= {16'h0000, cfg_attach, 7'h00, cfg_offline};
          end
        end else if (i_wb_adr == `CAP_REG_STATUS && !i_wb_we) begin
          o_wb_dat <= {16'h0000, o_full_duplex, 4'h0, clearing, xfer_on, last_cc};
        end
      end
    end
  end

endmodule

// ### dv/cap_port_cmd_sva.sv
`timescale 1ns/10ps
// ------------
// Port checker of the command interpreter.
// ------------
module cap_port_cmd_sva (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire o_wb_ack,
  input wire i_sio_valid,
  input wire [7:0] i_sio_code,
  input wire i_sio_parity_ok,
  input wire [2:0] i_sio_port,
  input wire o_sio_done,
  input wire [1:0] o_cond_code,
  input wire o_status_valid,
  input wire o_unit_check,
  input wire o_device_end,
  input wire o_data_req,
  input wire i_byte_strobe,
  input wire i_last_byte,
  input wire i_rx_valid,
  input wire o_cd_valid,
  input wire o_ci_valid,
  input wire [7:0] o_full_duplex,
  input wire [7:0] o_line_loop,
  input wire [7:0] o_modem_loop
);
  reg [2:0] port_q; // Port of the latest start.
  wire bad_code; // Code falls in the invalid set.
  assign bad_code = i_sio_code[3:0] == 4'h8 || i_sio_code[3:0] == 4'hC
    || i_sio_code[4:0] == 5'h10 || i_sio_code[4:0] == 5'h14;
  // Remember the addressed port so later cycles can index it.
  always @(posedge i_clock or posedge i_sys_rst)
    if (i_sys_rst) port_q <= 3'h0;
    else if (i_sio_valid) port_q <= i_sio_port;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  start_done_a: assert property (i_sio_valid |=> o_sio_done) else $error("no done");
  done_cause_a: assert property (o_sio_done |-> $past(i_sio_valid)) else $error("stray done");
  parity_rej_a: assert property (i_sio_valid && !i_sio_parity_ok |=> o_cond_code[0]
    && (o_cond_code[1] || o_unit_check)) else $error("parity kept");
  bad_code_a: assert property (i_sio_valid && bad_code |=> o_cond_code[0]) else $error("bad code kept");
  uchk_cc_a: assert property (o_unit_check |-> o_status_valid && o_cond_code == 2'h1)
    else $error("unit check code");
  last_end_a: assert property (o_data_req && i_byte_strobe && i_last_byte |=> o_device_end
    && o_status_valid ##1 !o_data_req) else $error("no end");
  ack_follow_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack long");
  line_loop_a: assert property (i_sio_valid && i_sio_code == 8'h0B ##1 o_cond_code == 2'h0
    |-> ##[0:2] o_line_loop[port_q] && o_full_duplex[port_q]) else $error("no loop");
  clear_port_a: assert property (i_sio_valid && i_sio_code[5:0] == 6'h0F ##1 o_cond_code == 2'h0
    |-> ##[0:2] !(o_full_duplex[port_q] | o_line_loop[port_q] | o_modem_loop[port_q]))
    else $error("no clear");
  detect_cause_a: assert property (o_cd_valid |-> $past(i_rx_valid)) else $error("stray detect");
  interp_cause_a: assert property (o_ci_valid |-> $past(o_cd_valid)) else $error("stray func");
  cover property (o_device_end);
  cover property (o_unit_check);
  cover property (o_cd_valid);
  cover property (|o_line_loop);
endmodule
bind cap_port_cmd cap_port_cmd_sva cap_port_cmd_sva_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .i_sio_valid(i_sio_valid),
  .i_sio_code(i_sio_code), .i_sio_parity_ok(i_sio_parity_ok), .i_sio_port(i_sio_port),
  .o_sio_done(o_sio_done), .o_cond_code(o_cond_code), .o_status_valid(o_status_valid),
  .o_unit_check(o_unit_check), .o_device_end(o_device_end), .o_data_req(o_data_req),
  .i_byte_strobe(i_byte_strobe), .i_last_byte(i_last_byte), .i_rx_valid(i_rx_valid),
  .o_cd_valid(o_cd_valid), .o_ci_valid(o_ci_valid), .o_full_duplex(o_full_duplex),
  .o_line_loop(o_line_loop), .o_modem_loop(o_modem_loop));

// ### dv/cap_chan_model.sv
`timescale 1ns/10ps
// ------------
// Channel model: start sequences and byte strobes.
// ------------
module cap_chan_model (
  input wire i_clock,
  input wire i_done,
  input wire [1:0] i_cc,
  input wire [7:0] i_rd,
  output logic o_valid,
  output logic [7:0] o_code,
  output logic o_par_ok,
  output logic [2:0] o_port,
  output logic o_strobe,
  output logic [7:0] o_wr,
  output logic o_last
);
  // Idle lines at time zero.
  initial begin
    o_valid = 1'b0;
    o_code = 8'h00;
    o_par_ok = 1'b1;
    o_port = 3'h0;
    o_strobe = 1'b0;
    o_wr = 8'h00;
    o_last = 1'b0;
  end
  // One start; the code line is scrambled once it is released.
  task automatic start(input logic [7:0] c, input logic [2:0] p, input logic ok, output logic [1:0] cc);
    @(posedge i_clock);
    o_valid <= 1'b1;
    o_code <= c;
    o_port <= p;
    o_par_ok <= ok;
    @(posedge i_clock);
    o_valid <= 1'b0;
    o_code <= ~c;
    #1;
    cc = i_done ? i_cc : 2'bxx;
  endtask
  // One byte; the offered byte is taken at the strobe edge.
  task automatic xfer(input logic [7:0] d, input logic l, output logic [7:0] r);
    @(posedge i_clock);
    @(posedge i_clock);
    o_strobe <= 1'b1;
    o_wr <= d;
    o_last <= l;
    @(posedge i_clock);
    r = i_rd;
    o_strobe <= 1'b0;
    o_wr <= ~d;
    o_last <= 1'b0;
  endtask
endmodule

// ### dv/tb.sv
`timescale 1ns/10ps
// ------------
// Self-checking bench of the command interpreter.
// ------------
module tb;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, rxv = 0;
  logic [3:0] adr = 0;
  logic [31:0] wd = 0, rd, w;
  logic [7:0] dsr = 0, rxc = 0, sc, bd, bo, k, r, a3, a4, fd, bz, mon, ll, ml, e [5];
  logic [7:0] tm [4] = '{8'h0B, 8'h0F, 8'h17, 8'h1B};
  logic [2:0] rxp = 0, spt, p;
  logic [1:0] cc, c, t;
  logic ack, sv, sok, done, stv, uc, de, dreq, ddir, bs, lb, cdv, civ;
  logic [4:0] cdc;
  logic [11:0] cif, wv;
  int n_fail = 0, n_compared = 0, ncyc = 0;
  initial forever #5 clk = ~clk;
  cap_port_cmd cap_port_cmd_inst (.i_clock(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wd), .o_wb_dat(rd), .o_wb_ack(ack),
    .i_sio_valid(sv), .i_sio_code(sc), .i_sio_parity_ok(sok), .i_sio_port(spt), .o_sio_done(done),
    .o_cond_code(cc), .o_status_valid(stv), .o_unit_check(uc), .o_device_end(de), .o_data_req(dreq),
    .o_data_dir(ddir), .i_byte_strobe(bs), .i_byte_data(bd), .i_last_byte(lb), .o_byte_data(bo),
    .i_dsr_event(dsr), .i_rx_valid(rxv), .i_rx_port(rxp), .i_rx_char(rxc), .o_cd_valid(cdv),
    .o_cd_code(cdc), .o_ci_valid(civ), .o_ci_func(cif), .o_full_duplex(fd), .o_busy_out(bz),
    .o_dsr_mon(mon), .o_line_loop(ll), .o_modem_loop(ml));
  cap_chan_model m (.i_clock(clk), .i_done(done), .i_cc(cc), .i_rd(bo), .o_valid(sv), .o_code(sc),
    .o_par_ok(sok), .o_port(spt), .o_strobe(bs), .o_wr(bd), .o_last(lb));
  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One classic bus cycle; read data lands in w.
  task automatic wbx(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1);
    w = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    wd <= ~d;
  endtask
  // Accepted start on the port under test.
  task automatic go(input logic [7:0] kk);
    m.start(kk, p, 1'b1, c);
    chk("cc", 0, c);
    repeat (3) @(posedge clk);
  endtask
  task automatic xf(input logic [7:0] d, input logic l);
    m.xfer(d, l, r);
    if (l) repeat (3) @(posedge clk);
  endtask
  // Expected control word byte by zero-based index.
  function automatic logic [7:0] pexp(input int i);
    case (i % 32)
      10, 12: return {6'h00, t};
      13, 14: return 8'hA0;
      18, 20: return a3;
      21, 22: return a4;
      default: return 8'h00;
    endcase
  endfunction
  // Cut a hang short.
  always @(posedge clk) begin
    ncyc++;
    if (ncyc == 20000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    k = 8'($urandom(3));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    m.start(8'h1B, 3'h0, 1'b1, c);
    chk("wipe cc", 2'h2, c);
    wbx(1'b0, 4'h0, 0);
    chk("cfg", 32'h0000FF00, w);
    wbx(1'b0, 4'hC, 0);
    chk("unmapped", 0, w);
    repeat (1030) @(posedge clk);
    wbx(1'b1, 4'h0, 32'h00007F00);
    m.start(8'h1B, 3'h7, 1'b1, c);
    chk("no adapter", 2'h1, c);
    wbx(1'b1, 4'h0, 32'h00007F01);
    m.start(8'h1B, 3'h0, 1'b1, c);
    chk("offline", 2'h3, c);
    wbx(1'b1, 4'h0, 32'h0000FF00);
    for (int i = 0; i < 4; i++) begin
      k = 8'($urandom);
      m.start(k, 3'h7, 1'b0, c);
      chk("parity", 2'h1, c);
      if (i < 2) k[3:0] = i ? 4'hC : 4'h8;
      else k[4:0] = i == 2 ? 5'h10 : 5'h14;
      m.start(k, 3'h7, 1'b1, c);
      chk("invalid", 2'h1, c);
    end
    p = 3'($urandom % 7);
    go(8'h1B);
    chk("duplex", 8'h01 << p, fd);
    go(8'h0B);
    chk("line loop", 8'h01 << p, ll);
    go(8'h0F);
    chk("clear", 0, fd | ll);
    go(8'h07);
    chk("modem", 8'h01 << p, ml);
    go(8'h0F);
    chk("modem clear", 0, ml | fd);
    foreach (tm[i]) begin
      go(8'h1F);
      chk("busy", 8'h01 << p, bz);
      go(tm[i]);
      chk("busy end", 0, bz);
    end
    dsr[p] <= 1'b1;
    @(posedge clk);
    dsr <= 8'h00;
    repeat (2) @(posedge clk);
    chk("mon off", 0, mon[p]);
    go(8'h17);
    chk("mon on", 1, mon[p]);
    t = 2'($urandom);
    a3 = 8'($urandom);
    a4 = 8'($urandom) & 8'hBF;
    go(8'h15);
    xf(8'hA0, 0);
    xf({6'h00, t}, 0);
    xf(8'h00, 0);
    xf(8'h00, 0);
    xf(8'h5A, 1);
    chk("overflow", 0, r);
    chk("cb1 clear", 0, fd[p]);
    go(8'h95);
    xf(a3, 0);
    xf(a4, 1);
    go(8'h16);
    chk("read dir", 2'h3, {dreq, ddir});
    m.start(8'h1A, p, 1'b1, c);
    chk("busy cc", 2'h2, c);
    wbx(1'b0, 4'h4, 0);
    chk("status", 32'h00000006, w);
    for (int i = 0; i < 34; i++) begin
      xf(8'h00, i == 33);
      chk("pcw", pexp(i), r);
    end
    go(8'h1B);
    go({t, 6'h19});
    chk("pre clear", 0, fd[p]);
    e[4] = 8'h00;
    for (int i = 0; i < 4; i++) begin
      e[i] = 8'($urandom) & 8'h1F;
      xf(e[i], i == 3);
    end
    go({t, 6'h1A});
    for (int i = 0; i < 3; i++) begin
      xf(8'h00, i == 2);
      chk("cd read", e[i], r);
    end
    wv = 12'($urandom);
    go({a3[1:0], 6'h1D});
    xf({4'h0, wv[11:8]}, 0);
    xf(wv[7:0], 1);
    go({a3[1:0], 6'h1E});
    xf(8'h00, 0);
    chk("ci high", wv[11:8], r[3:0]);
    xf(8'h00, 1);
    chk("ci low", wv[7:0], r);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      rxv <= 1'b1;
      rxp <= p;
      rxc <= 8'(i);
      @(posedge clk);
      rxv <= 1'b0;
      rxc <= ~rxc;
      #1;
      chk("detect", {1'b1, e[i][4:0]}, {cdv, cdc});
    end
    @(posedge clk);
    #1;
    chk("interp", {1'b1, wv}, {civ, cif});
    stop_test;
  end
endmodule
